/* logic/lp_cal_regs.svh */
// Register offsets, field positions, reset values and interval figures for
// the low-power calibration scheduler. Included by the scheduler logic only.
// What this block does
// - Software bit stands in for trigger pin.
// - Soft bit used when select zero; resets one.
// - Sleep code times sleep in autonomous low-power.
// - Sleep is (2^E+1)*256 clocks; code resets 4.
// - Wait wake settle time before calibrating.
// - Settle is (2^E+1)*256 clocks; code resets 1.
// - Trigger mode clear: sleep ends on timeout.
// - Trigger mode set: wake when trigger low.
// - Low-power enable gated by background calibration.
// - Select one uses pin, zero uses bit.
`ifndef LP_CAL_REGS_SVH
`define LP_CAL_REGS_SVH
`define SOFT_TRIG_OFFSET   8'h6c
`define LP_CTRL_OFFSET     8'h6e
`define SOFT_TRIG_RESET    8'h01
`define LP_CTRL_RESET      8'h88
`define SOFT_TRIG_BIT      0
`define LOW_POWER_CAL_ENABLE_BIT          0
`define WAKE_ON_TRIGGER_MODE_BIT        1
`define WAKE_LSB           3
`define WAKE_MSB           4
`define SLEEP_LSB          5
`define SLEEP_MSB          7
`define INTERVAL_UNIT      256
`define SLEEP_E0 3
`define SLEEP_E1 15
`define SLEEP_E2 18
`define SLEEP_E3 21
`define SLEEP_E4 24
`define SLEEP_E5 27
`define SLEEP_E6 30
`define SLEEP_E7 33
`define WAKE_E0 3
`define WAKE_E1 18
`define WAKE_E2 21
`define WAKE_E3 24
`endif

/* logic/lp_cal_pkg.sv */
// Types shared by the scheduler logic.
// Assumes the register header is on the include path.
package lp_cal_pkg;
   typedef enum logic [1:0] {
      st_idle   = 2'b00,
      st_sleep  = 2'b01,
      st_settle = 2'b10,
      st_cal    = 2'b11
   } sched_state_type;
endpackage

/* logic/interval_counter.sv */
// Down counter that times sleep and settle intervals in device clocks.
// Assumes a synchronous active-low reset and a single clock.
`timescale 1ns/100ps
module interval_counter #(
   parameter int WIDTH = 43
) (
   // Clock and reset
   input  wire logic             sys_clk,
   input  wire logic             rstn,
   // Control
   input  wire logic             load,
   input  wire logic [WIDTH-1:0] load_value,
   // Status
   output logic                  expired
);
   logic [WIDTH-1:0] remaining;

   // ======================================================================
   // Counting
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         remaining <= '0;
         expired   <= 1'b0;
      end else if (load) begin
         remaining <= load_value;
         expired   <= 1'b0;
      end else if (remaining != '0) begin
         remaining <= remaining - 1'b1;
         expired   <= (remaining == {{(WIDTH-1){1'b0}}, 1'b1});
      end
   end
endmodule // interval_counter

/* logic/low_power_bg_cal_scheduler.sv */
// Calibration trigger selection and low-power background calibration scheduler.
// Assumes a register port supplying address, write strobe and data each cycle,
// and a calibration engine that pulses cal_done when a core is calibrated.
`timescale 1ns/100ps
`include "lp_cal_regs.svh"
module low_power_bg_cal_scheduler #(
   parameter int CNT_WIDTH = 43,
   parameter int UNIT      = `INTERVAL_UNIT
) (
   // Clock and reset
   input  wire logic       sys_clk,
   input  wire logic       rstn,
   // Register port
   input  wire logic [7:0] reg_addr,
   input  wire logic       reg_wr,
   input  wire logic [7:0] reg_wdata,
   output logic      [7:0] reg_rdata,
   // Calibration configuration
   input  wire logic       trigger_source_select,
   input  wire logic       background_calibration_enable,
   input  wire logic       external_trigger_pin,
   // Calibration engine
   input  wire logic       cal_done,
   output logic            cal_trigger,
   output logic            core_asleep,
   output logic            cal_start
);
   logic                         software_calibration_trigger;
   logic [7:0]                   low_power_calibration_ctrl;
   logic [2:0]                   sleep_interval_code;
   logic [1:0]                   wake_settle_code;
   logic                         wake_on_trigger_mode;
   logic                         low_power_cal_enable;
   lp_cal_pkg::sched_state_type  state;
   logic                         load;
   logic [CNT_WIDTH-1:0]         load_value;
   logic                         expired;
   logic                         selected_trigger;
   logic                         lp_active;
   logic                         interval_done;
   logic                         wake_event;
   logic                         enter_sleep;
   logic                         enter_settle;
   logic                         settle_done;

   // Converts an exponent into (2^E + 1) * UNIT clock periods.
   function automatic logic [CNT_WIDTH-1:0] interval(input int e);
      logic [CNT_WIDTH-1:0] one;
      one = {{(CNT_WIDTH-1){1'b0}}, 1'b1};
      return ((one << e) + one) * CNT_WIDTH'(UNIT);
   endfunction

   function automatic logic [CNT_WIDTH-1:0] sleep_len(input logic [2:0] code);
      logic [CNT_WIDTH-1:0] v;
      unique case (code)
         3'h0: v = interval(`SLEEP_E0);
         3'h1: v = interval(`SLEEP_E1);
         3'h2: v = interval(`SLEEP_E2);
         3'h3: v = interval(`SLEEP_E3);
         3'h4: v = interval(`SLEEP_E4);
         3'h5: v = interval(`SLEEP_E5);
         3'h6: v = interval(`SLEEP_E6);
         3'h7: v = interval(`SLEEP_E7);
      endcase
      return v;
   endfunction

   function automatic logic [CNT_WIDTH-1:0] wake_len(input logic [1:0] code);
      logic [CNT_WIDTH-1:0] v;
      unique case (code)
         2'h0: v = interval(`WAKE_E0);
         2'h1: v = interval(`WAKE_E1);
         2'h2: v = interval(`WAKE_E2);
         2'h3: v = interval(`WAKE_E3);
      endcase
      return v;
   endfunction

   // Full-byte address match, shared by the write and the read decode.
   function automatic logic addr_hit(input logic [7:0] addr, input logic [7:0] offset);
      return addr == offset;
   endfunction

   // ======================================================================
   // Control fields
   assign sleep_interval_code  = low_power_calibration_ctrl[`SLEEP_MSB:`SLEEP_LSB];
   assign wake_settle_code     = low_power_calibration_ctrl[`WAKE_MSB:`WAKE_LSB];
   assign wake_on_trigger_mode = low_power_calibration_ctrl[`WAKE_ON_TRIGGER_MODE_BIT];
   assign low_power_cal_enable = low_power_calibration_ctrl[`LOW_POWER_CAL_ENABLE_BIT];

   // ======================================================================
   // Registers
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         software_calibration_trigger <= 1'(`SOFT_TRIG_RESET);
      end else if (reg_wr && addr_hit(reg_addr, `SOFT_TRIG_OFFSET)) begin
         software_calibration_trigger <= reg_wdata[`SOFT_TRIG_BIT];
      end
   end

   // The reserved bit of the control register is kept as written.
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         low_power_calibration_ctrl <= `LP_CTRL_RESET;
      end else if (reg_wr && addr_hit(reg_addr, `LP_CTRL_OFFSET)) begin
         low_power_calibration_ctrl <= reg_wdata;
      end
   end

   // Reserved bits of the trigger register read as zero; the control register
   // returns its reserved bit as written.
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         reg_rdata <= 8'h00;
      end else if (addr_hit(reg_addr, `SOFT_TRIG_OFFSET)) begin
         reg_rdata <= {7'h00, software_calibration_trigger};
      end else if (addr_hit(reg_addr, `LP_CTRL_OFFSET)) begin
         reg_rdata <= low_power_calibration_ctrl;
      end else begin
         reg_rdata <= 8'h00;
      end
   end

   // ======================================================================
   // Trigger selection
   assign selected_trigger = trigger_source_select ? external_trigger_pin
                                                   : software_calibration_trigger;
   assign lp_active = low_power_cal_enable
                      && background_calibration_enable;

   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         cal_trigger <= 1'b1;
      end else begin
         cal_trigger <= selected_trigger;
      end
   end

   // ======================================================================
   // Interval events
   // The reload flag masks the counter's stale expiry from the previous
   // interval during the one cycle before the new value lands.
   assign interval_done = expired && !load;
   assign wake_event    = wake_on_trigger_mode ? !selected_trigger
                                               : interval_done;
   assign enter_sleep   = lp_active && ((state == lp_cal_pkg::st_idle)
                                        || (state == lp_cal_pkg::st_cal && cal_done));
   assign enter_settle  = lp_active && (state == lp_cal_pkg::st_sleep) && wake_event;
   assign settle_done   = lp_active && (state == lp_cal_pkg::st_settle) && interval_done;

   // ======================================================================
   // Scheduler
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         state <= lp_cal_pkg::st_idle;
      end else if (!lp_active) begin
         state <= lp_cal_pkg::st_idle;
      end else begin
         unique case (state)
            lp_cal_pkg::st_idle: begin
               state <= lp_cal_pkg::st_sleep;
            end
            lp_cal_pkg::st_sleep: begin
               if (enter_settle) begin
                  state <= lp_cal_pkg::st_settle;
               end
            end
            lp_cal_pkg::st_settle: begin
               if (settle_done) begin
                  state <= lp_cal_pkg::st_cal;
               end
            end
            lp_cal_pkg::st_cal: begin
               if (cal_done) begin
                  state <= lp_cal_pkg::st_sleep;
               end
            end
         endcase
      end
   end

   // Codes are sampled at each reload, so a change made mid-interval takes
   // effect from the next sleep or wake, which keeps the counter coherent.
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         load       <= 1'b0;
         load_value <= '0;
      end else begin
         load <= enter_sleep || enter_settle;
         if (enter_sleep) begin
            load_value <= sleep_len(sleep_interval_code);
         end else if (enter_settle) begin
            load_value <= wake_len(wake_settle_code);
         end
      end
   end

   interval_counter #(.WIDTH(CNT_WIDTH)) u_interval (
      .sys_clk    (sys_clk),
      .rstn       (rstn),
      .load       (load),
      .load_value (load_value),
      .expired    (expired)
   );

   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         core_asleep <= 1'b0;
      end else begin
         core_asleep <= lp_active && (state == lp_cal_pkg::st_sleep);
      end
   end

   // One-cycle start pulse; the engine answers with cal_done when finished.
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         cal_start <= 1'b0;
      end else begin
         cal_start <= settle_done;
      end
   end
endmodule // low_power_bg_cal_scheduler

/* bench/lp_cal_checker.sv */
// Port checker for the low-power calibration scheduler.
// Assumes one clock and a synchronous active-low reset; bound from the bench.
`timescale 1ns/100ps
module lp_cal_checker #(
   parameter int UNIT = 256
) (
   // Clock, reset and register port
   input wire logic       sys_clk,
   input wire logic       rstn,
   input wire logic [7:0] reg_addr,
   input wire logic       reg_wr,
   input wire logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata,
   // Calibration side
   input wire logic       trigger_source_select,
   input wire logic       background_calibration_enable,
   input wire logic       external_trigger_pin,
   input wire logic       cal_done,
   input wire logic       cal_trigger,
   input wire logic       core_asleep,
   input wire logic       cal_start
);
   // =========================================================
   // Helper logic and assertions
   logic [31:0] awake_cnt;
   always_ff @(posedge sys_clk) begin
      if (!rstn || core_asleep) awake_cnt <= 32'h0;
      else awake_cnt <= awake_cnt + 32'h1;
   end
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rstn);
   sequence s_write(logic [7:0] a);
      reg_wr && reg_addr == a ##1 reg_addr == a;
   endsequence
   a_trig_from_pin: assert property (trigger_source_select |=> cal_trigger == $past(external_trigger_pin))
      else $error("trigger does not follow pin");
   a_soft_bit_drives: assert property (reg_wr && reg_addr == 8'h6c && !trigger_source_select
      ##1 !trigger_source_select |=> {7'h0, cal_trigger} == ($past(reg_wdata, 2) & 8'h01))
      else $error("trigger does not follow software bit");
   a_soft_trig_hold: assert property ((!trigger_source_select && !reg_wr)[*2] |=> $stable(cal_trigger))
      else $error("trigger moved without software write");
   a_ctrl_readback: assert property (s_write(8'h6e) |=> reg_rdata == $past(reg_wdata, 2))
      else $error("control readback wrong");
   a_soft_readback: assert property (s_write(8'h6c) |=> reg_rdata == ($past(reg_wdata, 2) & 8'h01))
      else $error("software trigger readback wrong");
   a_unmapped_zero: assert property (!(reg_addr inside {8'h6c, 8'h6e}) |=> reg_rdata == 8'h00)
      else $error("unmapped read not zero");
   a_start_one_cycle: assert property (cal_start |=> !cal_start)
      else $error("start pulse too long");
   a_settle_before_start: assert property (cal_start |-> !core_asleep && awake_cnt >= 32'(9 * UNIT))
      else $error("calibration started before settling");
   a_disable_wakes: assert property (!background_calibration_enable |-> ##[1:2] !core_asleep)
      else $error("core asleep with background calibration off");
endmodule // lp_cal_checker

/* bench/tb_top.sv */
// Self-checking bench for the calibration scheduler, interval unit shrunk to one clock.
// Assumes the design package, header and checker are compiled first.
`timescale 1ns/100ps
module tb_top;
   localparam int UNIT = 1;
   logic       sys_clk, rstn, reg_wr, cal_done, trigger_source_select;
   logic       background_calibration_enable, external_trigger_pin;
   logic       cal_trigger, core_asleep, cal_start;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
   int         fails = 0, check_count = 0, n;
   low_power_bg_cal_scheduler #(.UNIT(UNIT)) u_low_power_bg_cal_scheduler (.sys_clk, .rstn,
      .reg_addr, .reg_wr, .reg_wdata, .reg_rdata, .trigger_source_select,
      .background_calibration_enable, .external_trigger_pin, .cal_done, .cal_trigger,
      .core_asleep, .cal_start);
   // =========================================================
   // Expectations, drivers and compares
   function automatic int dur(bit sleep, int code);
      int e = code == 0 ? 3 : (sleep ? 12 : 15) + 3 * code;
      return ((1 << e) + 1) * UNIT;
   endfunction
   function automatic logic cond(int w);
      return w == 0 ? core_asleep : w == 1 ? !core_asleep : cal_start;
   endfunction
   task automatic finish_test();
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic chk8(string what, logic [7:0] exp, logic [7:0] got);
      check_count++;
      if (got !== exp) begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask
   // Interval figures carry a few cycles of state-machine overhead, hence the window.
   task automatic chk_dur(string what, int exp, int got);
      check_count++;
      if (got < exp || got > exp + 6) begin
         fails++;
         $display("MISMATCH %s expected %0d seen %0d", what, exp, got);
      end
   endtask
   task automatic wait_on(int w, int lim, output int cnt);
      for (cnt = 0; cond(w) !== 1'b1; cnt++) begin
         if (cnt > lim) begin
            fails++;
            $display("MISMATCH wait%0d expected %0d seen %0d", w, lim, cnt);
            finish_test();
         end
         @(negedge sys_clk);
      end
   endtask
   task automatic wr(logic [7:0] a, logic [7:0] v);
      @(negedge sys_clk);
      reg_addr = a;
      reg_wdata = v;
      reg_wr = 1'b1;
      @(negedge sys_clk);
      reg_wr = 1'b0;
   endtask
   task automatic rd(logic [7:0] a, logic [7:0] e);
      @(negedge sys_clk);
      reg_addr = a;
      @(negedge sys_clk);
      chk8("rdata", e, reg_rdata);
   endtask
   task automatic pulse_done();
      cal_done = 1'b1;
      @(negedge sys_clk);
      cal_done = 1'b0;
   endtask
   task automatic run_cycle(int sc, int wc);
      wait_on(0, 8, n);
      wait_on(1, dur(1, sc) + 8, n);
      chk_dur("sleep", dur(1, sc), n);
      wait_on(2, dur(0, wc) + 8, n);
      chk_dur("settle", dur(0, wc), n);
   endtask
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   initial begin
      {rstn, reg_wr, cal_done, trigger_source_select, background_calibration_enable} = 5'h0;
      {reg_addr, reg_wdata, d} = 24'h0;
      external_trigger_pin = 1'b1;
      void'($urandom(32'hcb38));
      repeat (5) @(negedge sys_clk);
      rstn = 1'b1;
      rd(8'h6c, 8'h01);
      rd(8'h6e, 8'h88);
      rd(8'h6d, 8'h00);
      $display("test reset done");
      repeat (24) begin
         d = 8'($urandom);
         wr(8'h6e, d);
         rd(8'h6e, d);
         wr(8'h6c, d);
         trigger_source_select = d[1];
         external_trigger_pin = d[2];
         rd(8'h6c, {7'h0, d[0]});
         chk8("trigger", {7'h0, d[1] ? d[2] : d[0]}, {7'h0, cal_trigger});
         chk8("asleep", 8'h0, {7'h0, core_asleep});
      end
      $display("test registers done");
      trigger_source_select = 1'b0;
      wr(8'h6c, 8'h01);
      // Codes below the advised floors keep the run short; the floors bind software only.
      wr(8'h6e, 8'h01);
      background_calibration_enable = 1'b1;
      run_cycle(0, 0);
      wr(8'h6e, 8'h21);
      pulse_done();
      run_cycle(1, 0);
      $display("test autonomous done");
      wr(8'h6e, 8'h03);
      external_trigger_pin = 1'b1;
      trigger_source_select = 1'b1;
      pulse_done();
      wait_on(0, 8, n);
      repeat (40) @(negedge sys_clk);
      chk8("asleep", 8'h1, {7'h0, core_asleep});
      background_calibration_enable = 1'b0;
      repeat (3) @(negedge sys_clk);
      chk8("asleep", 8'h0, {7'h0, core_asleep});
      background_calibration_enable = 1'b1;
      wait_on(0, 8, n);
      external_trigger_pin = 1'b0;
      wait_on(1, 6, n);
      wait_on(2, dur(0, 0) + 8, n);
      chk_dur("settle", dur(0, 0), n);
      $display("test trigger wake done");
      finish_test();
   end
endmodule // tb_top
bind low_power_bg_cal_scheduler lp_cal_checker #(.UNIT(UNIT)) u_lp_cal_checker (.sys_clk, .rstn,
   .reg_addr, .reg_wr, .reg_wdata, .reg_rdata, .trigger_source_select,
   .background_calibration_enable, .external_trigger_pin, .cal_done, .cal_trigger,
   .core_asleep, .cal_start);
